// ### logic/ptbi_cfg.svh
// register offsets, field positions, control reset value, divider width and response codes for the timebase block
`ifndef PTBI_CFG_SVH
`define PTBI_CFG_SVH
`define PTBI_CTRL_ADDR 4'h0
`define PTBI_STAT_ADDR 4'h4
`define PTBI_MASK_ADDR 4'h8
`define PTBI_BIT_RATE_LO 4
`define PTBI_BIT_RATE_HI 6
`define PTBI_BIT_FLAG 7
`define PTBI_BIT_ACK 3
`define PTBI_BIT_IRQEN 2
`define PTBI_BIT_EN 1
`define PTBI_CTRL_RESET 8'h00
`define PTBI_DIV_BITS 23
`define PTBI_RESP_OKAY 2'h0
`define PTBI_RESP_SLVERR 2'h2
`endif

// ### logic/ptbi_pkg.sv
// types shared by the timebase block
`default_nettype none
package ptbi_pkg;
  typedef enum logic [1:0] {
    PTBI_IDLE = 2'b00,
    PTBI_WRESP = 2'b01,
    PTBI_RRESP = 2'b10
  } ptbi_bus_state_t;
endpackage : ptbi_pkg
`default_nettype wire

// ### logic/ptbi_if.sv
// run, tap select, tick and wrap path between the control logic and the divider chain
`default_nettype none
interface ptbi_if;
  logic run;
  logic [2:0] rate;
  logic tap_set;
  logic tick;
  logic wrap;
  modport ctrl (output run, output rate, output tap_set, output tick, input wrap);
  modport chain (input run, input rate, input tap_set, input tick, output wrap);
endinterface : ptbi_if
`default_nettype wire

// ### logic/ptbi_divider.sv
// divider chain with selectable rollover tap
`include "ptbi_cfg.svh"
`default_nettype none
module ptbi_divider (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control side
  ptbi_if.chain dv
);
  logic [`PTBI_DIV_BITS-1:0] cnt_ff;
  logic [`PTBI_DIV_BITS-1:0] nxt_cnt;
  logic wrap_ff;
  logic nxt_wrap;
  logic [4:0] tap_idx;

  // tap index: divider 2^(n), wrap when bit (n-1) rises from zero to one
  always_comb
  begin
    case ({dv.tap_set, dv.rate})
      4'h0: tap_idx = 5'h0F;
      4'h1: tap_idx = 5'h0D;
      4'h2: tap_idx = 5'h0B;
      4'h3: tap_idx = 5'h07;
      4'h4: tap_idx = 5'h06;
      4'h5: tap_idx = 5'h05;
      4'h6: tap_idx = 5'h04;
      4'h7: tap_idx = 5'h03;
      4'h8: tap_idx = 5'h16;
      4'h9: tap_idx = 5'h14;
      4'hA: tap_idx = 5'h12;
      4'hB: tap_idx = 5'h0E;
      4'hC: tap_idx = 5'h0D;
      4'hD: tap_idx = 5'h0C;
      4'hE: tap_idx = 5'h0B;
      4'hF: tap_idx = 5'h0A;
      default: tap_idx = 5'h0F;
    endcase
  end

  // counter held at zero while disabled; rollover of the tap bit gives the event
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_wrap = 1'b0;
    if (!dv.run)
    begin
      nxt_cnt = '0;
    end
    else if (dv.tick)
    begin
      nxt_cnt = cnt_ff + 1'b1;
      // tap bit is bit (idx-1); its rising edge first comes after half the period,
      // then once every full period
      nxt_wrap = ~cnt_ff[tap_idx - 5'h01] & nxt_cnt[tap_idx - 5'h01];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= '0;
      wrap_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      wrap_ff <= nxt_wrap;
    end
  end

  assign dv.wrap = wrap_ff;
endmodule : ptbi_divider
`default_nettype wire

// ### logic/ptbi_top.sv
// timebase control register, AXI4-Lite slave, interrupt and clock select
// Contract
// - counter held zero while disabled
// - flag set at selected tap rollover
// - irq when flag and enable set; the code also needs the mask register bit set
// - ack write one clears flag, reads zero
// - first event about half period
// - external clock used when enabled
// - rate codes pick the tabulated taps
// - stop mode counts only if oscillator runs
// - otherwise inactive and unreachable in stop
// - wait mode counts, register unreachable
// - disabling leaves flag unchanged
// - reset clears both enables
// - fifteen stage divider chain; the code uses a 23 bit chain, taps up to 2^22 with tap_set_select
`include "ptbi_cfg.svh"
`default_nettype none
module ptbi_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // clock sources, pulses synchronous to aclk
  input wire logic external_clock,
  input wire logic internal_clock,
  // clock generator and power mode status
  input wire logic external_clock_on,
  input wire logic osc_run_in_stop,
  input wire logic tap_set_select,
  input wire logic wait_mode,
  input wire logic stop_mode,
  // interrupt
  output logic irq
);
  ptbi_if dv ();
  ptbi_pkg::ptbi_bus_state_t st_ff;
  ptbi_pkg::ptbi_bus_state_t nxt_st;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic mask_ff;
  logic nxt_mask;
  logic irq_ff;
  logic nxt_irq;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0] resp_ff;
  logic [1:0] nxt_resp;
  logic aw_ff;
  logic nxt_aw;
  logic w_ff;
  logic nxt_w;
  logic [3:0] awaddr_ff;
  logic [3:0] nxt_awaddr;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic wstrb0_ff;
  logic nxt_wstrb0;
  logic blocked;
  logic active;
  logic do_write;
  logic set_flag;

  // cpu cannot reach the register in wait or stop
  assign blocked = wait_mode | stop_mode;
  // in stop only an oscillator kept running lets the chain count
  assign active = !stop_mode || osc_run_in_stop;
  assign dv.run = ctrl_ff[`PTBI_BIT_EN];
  assign dv.rate = ctrl_ff[`PTBI_BIT_RATE_HI:`PTBI_BIT_RATE_LO];
  assign dv.tap_set = tap_set_select;
  // external source wins whenever it is switched on
  assign dv.tick = active & (external_clock_on ? external_clock : internal_clock);
  assign set_flag = dv.wrap;
  assign do_write = aw_ff & w_ff & (st_ff == ptbi_pkg::PTBI_IDLE);

  ptbi_divider u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .dv(dv)
  );

  // bus handshake: address and data latched in either order, one answer each
  always_comb
  begin
    nxt_st = st_ff;
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb0 = wstrb0_ff;
    nxt_rdata = rdata_ff;
    nxt_resp = resp_ff;
    if (s_axi_awvalid && !aw_ff && st_ff == ptbi_pkg::PTBI_IDLE)
    begin
      nxt_aw = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff && st_ff == ptbi_pkg::PTBI_IDLE)
    begin
      nxt_w = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb0 = s_axi_wstrb[0];
    end
    case (st_ff)
      ptbi_pkg::PTBI_IDLE:
      begin
        if (do_write)
        begin
          nxt_aw = 1'b0;
          nxt_w = 1'b0;
          nxt_st = ptbi_pkg::PTBI_WRESP;
          // unreachable register in low power answers with an error
          nxt_resp = (blocked || awaddr_ff > `PTBI_MASK_ADDR || awaddr_ff[1:0] != 2'h0)
            ? `PTBI_RESP_SLVERR : `PTBI_RESP_OKAY;
        end
        else if (s_axi_arvalid && !aw_ff && !w_ff)
        begin
          nxt_st = ptbi_pkg::PTBI_RRESP;
          nxt_resp = `PTBI_RESP_OKAY;
          nxt_rdata = 32'h0000_0000;
          if (blocked)
          begin
            nxt_resp = `PTBI_RESP_SLVERR;
          end
          else
          begin
            case (s_axi_araddr)
              `PTBI_CTRL_ADDR: nxt_rdata = {24'h000000, ctrl_ff};
              `PTBI_STAT_ADDR: nxt_rdata = {31'h0, ctrl_ff[`PTBI_BIT_FLAG]};
              `PTBI_MASK_ADDR: nxt_rdata = {31'h0, mask_ff};
              default: nxt_resp = `PTBI_RESP_SLVERR;
            endcase
          end
        end
      end
      ptbi_pkg::PTBI_WRESP:
      begin
        if (s_axi_bready)
        begin
          nxt_st = ptbi_pkg::PTBI_IDLE;
        end
      end
      ptbi_pkg::PTBI_RRESP:
      begin
        if (s_axi_rready)
        begin
          nxt_st = ptbi_pkg::PTBI_IDLE;
        end
      end
      default: nxt_st = ptbi_pkg::PTBI_IDLE;
    endcase
  end

  // register file; a rollover in the clearing cycle keeps the flag set
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    if (do_write && !blocked && wstrb0_ff)
    begin
      if (awaddr_ff == `PTBI_CTRL_ADDR)
      begin
        nxt_ctrl[`PTBI_BIT_RATE_HI:`PTBI_BIT_RATE_LO] =
          wdata_ff[`PTBI_BIT_RATE_HI:`PTBI_BIT_RATE_LO];
        nxt_ctrl[`PTBI_BIT_IRQEN] = wdata_ff[`PTBI_BIT_IRQEN];
        nxt_ctrl[`PTBI_BIT_EN] = wdata_ff[`PTBI_BIT_EN];
        if (wdata_ff[`PTBI_BIT_ACK])
        begin
          nxt_ctrl[`PTBI_BIT_FLAG] = 1'b0;
        end
      end
      else if (awaddr_ff == `PTBI_STAT_ADDR && wdata_ff[0])
      begin
        nxt_ctrl[`PTBI_BIT_FLAG] = 1'b0;
      end
      else if (awaddr_ff == `PTBI_MASK_ADDR)
      begin
        nxt_mask = wdata_ff[0];
      end
    end
    if (set_flag)
    begin
      nxt_ctrl[`PTBI_BIT_FLAG] = 1'b1;
    end
    nxt_ctrl[`PTBI_BIT_ACK] = 1'b0;
    nxt_ctrl[0] = 1'b0;
    // flag and enable raise the cpu request, mask register also gates it
    nxt_irq = nxt_ctrl[`PTBI_BIT_FLAG] & nxt_ctrl[`PTBI_BIT_IRQEN] & nxt_mask;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= ptbi_pkg::PTBI_IDLE;
      ctrl_ff <= `PTBI_CTRL_RESET;
      mask_ff <= 1'b1;
      irq_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      resp_ff <= 2'h0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb0_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      rdata_ff <= nxt_rdata;
      resp_ff <= nxt_resp;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb0_ff <= nxt_wstrb0;
    end
  end

  // ready flags are registered: awready/wready pulse for one cycle as the request is latched into the free slot
  logic awready_ff;
  logic wready_ff;
  logic arready_ff;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
    end
    else
    begin
      awready_ff <= s_axi_awvalid && !aw_ff && !awready_ff && st_ff == ptbi_pkg::PTBI_IDLE;
      wready_ff <= s_axi_wvalid && !w_ff && !wready_ff && st_ff == ptbi_pkg::PTBI_IDLE;
      // one-cycle pulse with the first cycle of the read answer
      arready_ff <= (st_ff == ptbi_pkg::PTBI_IDLE) && (nxt_st == ptbi_pkg::PTBI_RRESP);
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_bvalid = (st_ff == ptbi_pkg::PTBI_WRESP);
  assign s_axi_bresp = resp_ff;
  assign s_axi_rvalid = (st_ff == ptbi_pkg::PTBI_RRESP);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = resp_ff;
  assign irq = irq_ff;
endmodule : ptbi_top
`default_nettype wire

// ### bench/ptbi_chk.sv
// port checker for the timebase block
`include "ptbi_cfg.svh"
`default_nettype none
module ptbi_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mode and interrupt
  input wire logic wait_mode,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] quiet_ff;
  logic [2:0] nxt_quiet;
  logic ctrl_rd;
  // cycles since the last write request, saturating; a clear may land a few cycles late
  always_comb nxt_quiet = (s_axi_awvalid || s_axi_wvalid) ? 3'h0 :
    ((quiet_ff == 3'h7) ? quiet_ff : quiet_ff + 3'h1);
  always_ff @(posedge aclk) quiet_ff <= !aresetn ? 3'h0 : nxt_quiet;
  // accepted read answer of the control register
  assign ctrl_rd = s_axi_rvalid && s_axi_arvalid && (s_axi_araddr == `PTBI_CTRL_ADDR) &&
    (s_axi_rresp == `PTBI_RESP_OKAY);
  sequence rd_go;
    $rose(s_axi_arvalid) && !s_axi_awvalid && !s_axi_bvalid;
  endsequence
  sequence wr_go;
    $rose(s_axi_awvalid) && $rose(s_axi_wvalid);
  endsequence
  chk_read_answer: assert property (rd_go |-> ##[1:3] s_axi_rvalid)
    else $error("read not answered in time");
  chk_write_answer: assert property (wr_go |-> ##[1:6] s_axi_bvalid)
    else $error("write not answered in time");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped early");
  chk_wait_refused: assert property ($rose(s_axi_bvalid) && wait_mode |-> s_axi_bresp == `PTBI_RESP_SLVERR)
    else $error("write accepted in wait mode");
  chk_ack_reads_zero: assert property (ctrl_rd |-> s_axi_rdata[`PTBI_BIT_ACK] == 1'b0)
    else $error("acknowledge bit read as one");
  chk_irq_cause: assert property (ctrl_rd && irq |-> s_axi_rdata[`PTBI_BIT_FLAG] && s_axi_rdata[`PTBI_BIT_IRQEN])
    else $error("irq without flag and enable");
  chk_irq_sticky: assert property (irq && quiet_ff == 3'h7 && !s_axi_bvalid |=> irq)
    else $error("irq dropped without a write");
  chk_reset_quiet: assert property ($rose(aresetn) |-> !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule : ptbi_chk
bind ptbi_top ptbi_chk chk_u (.*);
`default_nettype wire

// ### bench/periodic_timebase_interrupt_tb.sv
// self-checking bench for the timebase block
`include "ptbi_cfg.svh"
`default_nettype none
module periodic_timebase_interrupt_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic external_clock, internal_clock, external_clock_on, osc_run_in_stop;
  logic tap_set_select, wait_mode, stop_mode, irq;
  int fails, samples_checked, cyc, t0;
  ptbi_top dut_u (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // write: address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wait_irq(input int lim, input logic want);
    int n;
    n = 0;
    while (irq !== want && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    check(irq, want);
  endtask : wait_irq
  task automatic t_reset;
    rd(`PTBI_CTRL_ADDR);
    check(d, 32'h00);
    rd(`PTBI_MASK_ADDR);
    check(d, 32'h01);
    check(irq, 1'b0);
  endtask : t_reset
  // rate code 3 taps 128 ticks; internal tick every cycle
  task automatic t_period;
    wr(`PTBI_CTRL_ADDR, 32'h36);
    t0 = cyc;
    wait_irq(200, 1'b1);
    check(cyc - t0 < 96, 1'b1);
    rd(`PTBI_CTRL_ADDR);
    check(d, 32'hB6);
    wr(`PTBI_CTRL_ADDR, 32'h3E);
    wait_irq(20, 1'b0);
    rd(`PTBI_CTRL_ADDR);
    check(d, 32'h36);
    wait_irq(200, 1'b1);
    t0 = cyc;
    wr(`PTBI_CTRL_ADDR, 32'h3E);
    wait_irq(20, 1'b0);
    wait_irq(200, 1'b1);
    check(cyc - t0, 128);
  endtask : t_period
  task automatic t_disable;
    wr(`PTBI_CTRL_ADDR, 32'h34);
    rd(`PTBI_CTRL_ADDR);
    check(d, 32'hB4);
    wr(`PTBI_STAT_ADDR, 32'h01);
    repeat (300) @(posedge aclk);
    check(irq, 1'b0);
    wr(`PTBI_CTRL_ADDR, 32'h36);
    wait_irq(200, 1'b1);
    wr(`PTBI_MASK_ADDR, 32'h00);
    wait_irq(10, 1'b0);
    wr(`PTBI_MASK_ADDR, 32'h01);
    wait_irq(10, 1'b1);
    wr(`PTBI_STAT_ADDR, 32'h01);
    wait_irq(10, 1'b0);
  endtask : t_disable
  task automatic t_refuse;
    wait_mode <= 1'b1;
    wr(`PTBI_CTRL_ADDR, 32'h00);
    check(r, `PTBI_RESP_SLVERR);
    rd(`PTBI_CTRL_ADDR);
    check(r, `PTBI_RESP_SLVERR);
    wait_mode <= 1'b0;
    rd(4'hC);
    check(r, `PTBI_RESP_SLVERR);
    rd(`PTBI_CTRL_ADDR);
    check(d, 32'h36);
  endtask : t_refuse
  // stop without a running oscillator refuses the register; external source selection
  task automatic t_modes;
    stop_mode <= 1'b1;
    rd(`PTBI_CTRL_ADDR);
    check(r, `PTBI_RESP_SLVERR);
    stop_mode <= 1'b0;
    external_clock_on <= 1'b1;
    wr(`PTBI_CTRL_ADDR, 32'h34);
    wr(`PTBI_STAT_ADDR, 32'h01);
    wr(`PTBI_CTRL_ADDR, 32'h36);
    repeat (300) @(posedge aclk);
    check(irq, 1'b0);
    external_clock <= 1'b1;
    wait_irq(200, 1'b1);
  endtask : t_modes
  task automatic give_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // hang guard: the sequence needs well under two thousand cycles
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00;
    s_axi_wstrb = 4'hF;
    {external_clock, external_clock_on, osc_run_in_stop, tap_set_select} = 4'h0;
    {wait_mode, stop_mode} = 2'h0;
    internal_clock = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_period();
    t_disable();
    t_refuse();
    t_modes();
    give_verdict();
  end
endmodule : periodic_timebase_interrupt_tb
`default_nettype wire
